// File: rtl/host_port_pkg.sv
package host_port_pkg;

	localparam int ADDR_W = 32;
	localparam int DATA_W = 32;
	localparam int BS_W = 4;

	// Address that the core fetches the nonmaskable-interrupt handler start from.
	localparam logic [ADDR_W-1:0] NMI_VECTOR_ADDR = 32'hfffffee0;
	// Implicit addressing steps one 32-bit word at a time.
	localparam logic [ADDR_W-1:0] WORD_STEP = 32'h00000004;
	// Window of internal registers; a host write there is captured, not sent to memory.
	localparam logic [ADDR_W-1:0] IO_BASE = 32'hc0000000;
	localparam logic [ADDR_W-1:0] IO_MASK = 32'hffe00000;

	// Legal byte-select patterns during implicit addressing (driven by the host).
	localparam logic [BS_W-1:0] BS_ALL = 4'hf;
	localparam logic [BS_W-1:0] BS_LOW_HALF = 4'h3;
	localparam logic [BS_W-1:0] BS_HIGH_HALF = 4'hc;
	// Byte lane whose access closes a location and may advance the address.
	localparam int LAST_BYTE = 3;

	// Each ref_clk period is one quarter phase of a machine state.
	localparam logic [1:0] QTR_FIRST = 2'h0;
	localparam logic [1:0] QTR_LAST = 2'h3;
	localparam logic [1:0] QTR_STEP = 2'h1;

	localparam logic [ADDR_W-1:0] ADDR_RESET = 32'h00000000;
	localparam logic [DATA_W-1:0] DATA_RESET = 32'h00000000;

	typedef enum logic [1:0] {
		KIND_READ,
		KIND_PREFETCH,
		KIND_WRITE,
		KIND_REG
	} cycle_kind_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_MEM,
		ST_REGWR
	} port_state_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic write;
		logic prefetch;
	} mem_req_t;

	typedef struct packed {
		logic cs_n;
		logic rd_n;
		logic wr_n;
		logic [BS_W-1:0] bs;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] lad;
	} host_pins_t;

	localparam mem_req_t MEM_REQ_RESET = '{addr: ADDR_RESET, write: 1'b0, prefetch: 1'b0};

endpackage

// File: rtl/req_buffer.sv
`timescale 1ns/100ps
`default_nettype none

// Two-entry buffer; in_ready is registered so the filling side sees no combinational path.
module req_buffer
	import host_port_pkg::*;
(
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic in_valid,
	input wire mem_req_t in_data,
	output logic in_ready,
	output logic out_valid,
	output mem_req_t out_data,
	input wire logic out_ready
);

	logic head_valid;
	logic spare_valid;
	mem_req_t spare_data;
	logic next_head_valid;
	logic next_spare_valid;
	mem_req_t next_head_data;
	mem_req_t next_spare_data;
	logic take;
	logic give;

	assign take = in_valid && !spare_valid;
	assign give = head_valid && out_ready;
	assign out_valid = head_valid;
	assign in_ready = !spare_valid;

	always_comb begin
		next_head_valid = head_valid;
		next_spare_valid = spare_valid;
		next_head_data = out_data;
		next_spare_data = spare_data;
		if (give) begin
			next_head_valid = spare_valid;
			next_head_data = spare_data;
			next_spare_valid = 1'b0;
		end
		if (take) begin
			if (!next_head_valid) begin
				next_head_valid = 1'b1;
				next_head_data = in_data;
			end else begin
				next_spare_valid = 1'b1;
				next_spare_data = in_data;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			head_valid <= 1'b0;
			spare_valid <= 1'b0;
			out_data <= MEM_REQ_RESET;
			spare_data <= MEM_REQ_RESET;
		end else begin
			head_valid <= next_head_valid;
			spare_valid <= next_spare_valid;
			out_data <= next_head_data;
			spare_data <= next_spare_data;
		end
	end

endmodule

`default_nettype wire

// File: rtl/host_port_ctrl.sv
`timescale 1ns/100ps
`default_nettype none

module host_port_ctrl
	import host_port_pkg::*;
(
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic host_chip_select_n,
	input wire logic host_read_strobe_n,
	input wire logic host_write_strobe_n,
	input wire logic [BS_W-1:0] host_byte_selects,
	input wire logic [ADDR_W-1:0] host_addr,
	input wire logic [DATA_W-1:0] local_addr_data_bus,
	output logic host_ready_out,
	output logic transceiver_dir_strobe,
	output logic transceiver_output_enable_n,
	input wire logic auto_increment_enable,
	input wire logic prefetch_on_write_select,
	output logic mem_req_valid,
	output mem_req_t mem_req,
	input wire logic mem_req_ready,
	input wire logic mem_cycle_done,
	output logic reg_wr_valid,
	output logic [ADDR_W-1:0] reg_wr_addr,
	output logic [DATA_W-1:0] reg_wr_data,
	input wire logic halt_request_bit,
	input wire logic host_nmi_set,
	input wire logic irq_context_skip_bit,
	input wire logic cache_flush_bit,
	input wire logic core_instr_boundary,
	input wire logic core_interruptible_point,
	output logic halt_acknowledge_bit,
	output logic core_halted,
	output logic nmi_pending,
	output logic nmi_take,
	output logic [ADDR_W-1:0] nmi_vector,
	output logic nmi_save_context,
	output logic icache_flush
);

	// Host pins arrive asynchronously; two stages before anything looks at them.
	host_pins_t pins_raw;
	host_pins_t pins_s1;
	host_pins_t pins_s2;
	host_pins_t pins_d;

	assign pins_raw = '{cs_n: host_chip_select_n, rd_n: host_read_strobe_n,
		wr_n: host_write_strobe_n, bs: host_byte_selects, addr: host_addr,
		lad: local_addr_data_bus};

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			pins_s1 <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, bs: '0, addr: ADDR_RESET,
				lad: DATA_RESET};
			pins_s2 <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, bs: '0, addr: ADDR_RESET,
				lad: DATA_RESET};
			pins_d <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, bs: '0, addr: ADDR_RESET,
				lad: DATA_RESET};
		end else begin
			pins_s1 <= pins_raw;
			pins_s2 <= pins_s1;
			pins_d <= pins_s2;
		end
	end

	logic strobe_n;
	logic strobe_prev_n;
	logic lead;
	logic trail;
	logic cs_fall;

	// The request strobe is low only while chip select and a strobe are both low.
	assign strobe_n = pins_s2.cs_n | (pins_s2.rd_n & pins_s2.wr_n);
	assign strobe_prev_n = pins_d.cs_n | (pins_d.rd_n & pins_d.wr_n);
	assign lead = strobe_prev_n && !strobe_n;
	assign trail = !strobe_prev_n && strobe_n;
	assign cs_fall = pins_d.cs_n && !pins_s2.cs_n;

	// Quarter-phase counter: four ref_clk periods make one machine state.
	logic [1:0] qtr;
	logic [1:0] next_qtr;

	always_comb begin
		next_qtr = qtr + QTR_STEP;
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			qtr <= QTR_FIRST;
		end else begin
			qtr <= next_qtr;
		end
	end

	port_state_t state, next_state;
	logic [ADDR_W-1:0] cur_addr, next_cur_addr;
	logic [ADDR_W-1:0] held_addr, next_held_addr;
	logic held_valid, next_held_valid;
	logic req_active, next_req_active;
	logic req_write, next_req_write;
	logic req_last, next_req_last;
	logic [ADDR_W-1:0] req_addr, next_req_addr;
	logic pend, next_pend;
	logic late, next_late;
	cycle_kind_t pend_kind, next_pend_kind;
	logic [ADDR_W-1:0] pend_addr, next_pend_addr;
	cycle_kind_t cyc_kind, next_cyc_kind;
	logic [ADDR_W-1:0] cyc_addr, next_cyc_addr;
	logic after_pf, next_after_pf;
	logic next_ready;
	logic next_transceiver_dir_strobe;
	logic next_hoe_n;
	logic next_reg_wr_valid;
	logic [ADDR_W-1:0] next_reg_wr_addr;
	logic [DATA_W-1:0] next_reg_wr_data;

	logic push;
	logic buf_in_ready;
	logic idle_now;
	logic done;
	logic [ADDR_W-1:0] addr_now;
	logic [ADDR_W-1:0] addr_after;
	logic read_hit;
	logic req_is_io;
	logic cyc_fetched;
	mem_req_t push_data;

	assign idle_now = (state == ST_IDLE) && !pend && !after_pf;
	assign addr_now = cs_fall ? pins_s2.addr : cur_addr;
	assign addr_after = req_addr + WORD_STEP;
	assign read_hit = auto_increment_enable && held_valid && (held_addr == addr_now);
	assign req_is_io = (req_addr & IO_MASK) == IO_BASE;
	assign cyc_fetched = (cyc_kind == KIND_READ) || (cyc_kind == KIND_PREFETCH);
	assign done = ((state == ST_MEM) && mem_cycle_done) ||
		((state == ST_REGWR) && (qtr == QTR_LAST));
	assign push_data = '{addr: pend_addr, write: pend_kind == KIND_WRITE,
		prefetch: pend_kind == KIND_PREFETCH};

	always_comb begin
		next_state = state;
		next_cur_addr = cur_addr;
		next_held_addr = held_addr;
		next_held_valid = held_valid;
		next_req_active = req_active;
		next_req_write = req_write;
		next_req_last = req_last;
		next_req_addr = req_addr;
		next_pend = pend;
		next_late = late;
		next_pend_kind = pend_kind;
		next_pend_addr = pend_addr;
		next_cyc_kind = cyc_kind;
		next_cyc_addr = cyc_addr;
		next_after_pf = after_pf;
		next_ready = host_ready_out;
		next_transceiver_dir_strobe = transceiver_dir_strobe;
		next_hoe_n = transceiver_output_enable_n;
		next_reg_wr_valid = 1'b0;
		next_reg_wr_addr = reg_wr_addr;
		next_reg_wr_data = reg_wr_data;
		push = 1'b0;
		if (cs_fall) begin
			next_cur_addr = pins_s2.addr;
		end
		if (lead) begin
			next_req_active = 1'b1;
			next_req_write = !pins_s2.wr_n;
			next_req_last = pins_s2.bs[LAST_BYTE];
			next_req_addr = addr_now;
			if (!pins_s2.wr_n) begin
				next_ready = idle_now;
			end else if (read_hit) begin
				next_ready = idle_now;
			end else begin
				next_ready = 1'b0;
				if (idle_now) begin
					next_pend = 1'b1;
					next_pend_kind = KIND_READ;
					next_pend_addr = addr_now;
					next_late = (qtr == QTR_LAST);
				end
			end
		end
		if (trail) begin
			next_req_active = 1'b0;
			next_ready = 1'b0;
			if (req_write) begin
				next_held_valid = 1'b0;
				next_pend = 1'b1;
				next_pend_kind = req_is_io ? KIND_REG : KIND_WRITE;
				next_pend_addr = req_addr;
				next_late = (qtr == QTR_LAST);
				if (auto_increment_enable && req_last) begin
					next_cur_addr = addr_after;
					next_after_pf = prefetch_on_write_select && !req_is_io;
				end
			end else if (auto_increment_enable && req_last) begin
				next_cur_addr = addr_after;
				if (!prefetch_on_write_select) begin
					next_pend = 1'b1;
					next_pend_kind = KIND_PREFETCH;
					next_pend_addr = addr_after;
					next_late = (qtr == QTR_LAST);
				end
			end
		end
		// A pending cycle starts only on a machine-state boundary; a late strobe waits one more.
		if ((qtr == QTR_LAST) && pend) begin
			if (late) begin
				next_late = 1'b0;
			end else if ((state == ST_IDLE) && buf_in_ready) begin
				push = (pend_kind != KIND_REG);
				next_pend = 1'b0;
				next_cyc_kind = pend_kind;
				next_cyc_addr = pend_addr;
				next_state = (pend_kind == KIND_REG) ? ST_REGWR : ST_MEM;
				next_hoe_n = !((pend_kind == KIND_WRITE) || (pend_kind == KIND_REG));
				next_transceiver_dir_strobe = !((pend_kind == KIND_READ) || (pend_kind == KIND_PREFETCH));
			end
		end
		if (done) begin
			next_state = ST_IDLE;
			next_hoe_n = 1'b1;
			next_transceiver_dir_strobe = 1'b1;
			if (state == ST_REGWR) begin
				next_reg_wr_valid = 1'b1;
				next_reg_wr_addr = cyc_addr;
				next_reg_wr_data = pins_s2.lad;
			end
			if (cyc_fetched) begin
				next_held_addr = cyc_addr;
				next_held_valid = 1'b1;
			end
			if (after_pf && (cyc_kind == KIND_WRITE) && !next_pend) begin
				// Ready stays low here so a waiting request sees the prefetched word.
				next_after_pf = 1'b0;
				next_pend = 1'b1;
				next_pend_kind = KIND_PREFETCH;
				next_pend_addr = next_cur_addr;
				next_late = (qtr == QTR_LAST);
			end else if (next_req_active && !next_ready) begin
				if (next_req_write) begin
					next_ready = 1'b1;
				end else if (cyc_fetched && (cyc_addr == next_req_addr)) begin
					next_ready = 1'b1;
				end else if (!next_pend) begin
					next_pend = 1'b1;
					next_pend_kind = KIND_READ;
					next_pend_addr = next_req_addr;
					next_late = (qtr == QTR_LAST);
				end
			end
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			state <= ST_IDLE;
			cur_addr <= ADDR_RESET;
			held_addr <= ADDR_RESET;
			held_valid <= 1'b0;
			req_active <= 1'b0;
			req_write <= 1'b0;
			req_last <= 1'b0;
			req_addr <= ADDR_RESET;
			pend <= 1'b0;
			late <= 1'b0;
			pend_kind <= KIND_READ;
			pend_addr <= ADDR_RESET;
			cyc_kind <= KIND_READ;
			cyc_addr <= ADDR_RESET;
			after_pf <= 1'b0;
			host_ready_out <= 1'b0;
			transceiver_dir_strobe <= 1'b1;
			transceiver_output_enable_n <= 1'b1;
			reg_wr_valid <= 1'b0;
			reg_wr_addr <= ADDR_RESET;
			reg_wr_data <= DATA_RESET;
		end else begin
			state <= next_state;
			cur_addr <= next_cur_addr;
			held_addr <= next_held_addr;
			held_valid <= next_held_valid;
			req_active <= next_req_active;
			req_write <= next_req_write;
			req_last <= next_req_last;
			req_addr <= next_req_addr;
			pend <= next_pend;
			late <= next_late;
			pend_kind <= next_pend_kind;
			pend_addr <= next_pend_addr;
			cyc_kind <= next_cyc_kind;
			cyc_addr <= next_cyc_addr;
			after_pf <= next_after_pf;
			host_ready_out <= next_ready;
			transceiver_dir_strobe <= next_transceiver_dir_strobe;
			transceiver_output_enable_n <= next_hoe_n;
			reg_wr_valid <= next_reg_wr_valid;
			reg_wr_addr <= next_reg_wr_addr;
			reg_wr_data <= next_reg_wr_data;
		end
	end

	// A full buffer holds the pending cycle back instead of dropping it.
	req_buffer u_req_buffer (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.in_valid(push),
		.in_data(push_data),
		.in_ready(buf_in_ready),
		.out_valid(mem_req_valid),
		.out_data(mem_req),
		.out_ready(mem_req_ready)
	);

	// Halt and host interrupt control.
	logic halted, next_halted;
	logic next_nmi_pending;
	logic next_nmi_take;
	logic [ADDR_W-1:0] next_nmi_vector;
	logic next_save_context;
	logic take_now;

	// The core is not executing while halted, so the interrupt waits for release.
	assign take_now = nmi_pending && core_interruptible_point && !halted;

	always_comb begin
		next_halted = halted;
		next_nmi_pending = nmi_pending;
		next_nmi_vector = nmi_vector;
		next_save_context = nmi_save_context;
		next_nmi_take = take_now;
		if (take_now) begin
			next_nmi_pending = 1'b0;
			next_nmi_vector = NMI_VECTOR_ADDR;
			next_save_context = !irq_context_skip_bit;
		end
		if (host_nmi_set) begin
			next_nmi_pending = 1'b1;
		end
		if (!halted) begin
			if (halt_request_bit && (core_instr_boundary || take_now)) begin
				next_halted = 1'b1;
			end
		end else if (!halt_request_bit) begin
			next_halted = 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			halted <= 1'b0;
			core_halted <= 1'b0;
			halt_acknowledge_bit <= 1'b0;
			nmi_pending <= 1'b0;
			nmi_take <= 1'b0;
			nmi_vector <= ADDR_RESET;
			nmi_save_context <= 1'b1;
			icache_flush <= 1'b0;
		end else begin
			halted <= next_halted;
			core_halted <= next_halted;
			halt_acknowledge_bit <= next_halted;
			nmi_pending <= next_nmi_pending;
			nmi_take <= next_nmi_take;
			nmi_vector <= next_nmi_vector;
			nmi_save_context <= next_save_context;
			icache_flush <= cache_flush_bit;
		end
	end

endmodule

`default_nettype wire

// File: verif/host_port_props.sv
`timescale 1ns/100ps
`default_nettype none

module host_port_props
	import host_port_pkg::*;
(
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic host_chip_select_n,
	input wire logic host_read_strobe_n,
	input wire logic host_write_strobe_n,
	input wire logic [DATA_W-1:0] local_addr_data_bus,
	input wire logic host_ready_out,
	input wire logic reg_wr_valid,
	input wire logic [ADDR_W-1:0] reg_wr_addr,
	input wire logic [DATA_W-1:0] reg_wr_data,
	input wire logic halt_request_bit,
	input wire logic host_nmi_set,
	input wire logic irq_context_skip_bit,
	input wire logic cache_flush_bit,
	input wire logic core_instr_boundary,
	input wire logic halt_acknowledge_bit,
	input wire logic core_halted,
	input wire logic nmi_pending,
	input wire logic nmi_take,
	input wire logic [ADDR_W-1:0] nmi_vector,
	input wire logic nmi_save_context,
	input wire logic icache_flush
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);

	// Ready may only stand while the combined strobe is active, allowing for the sync delay.
	wire host_strobe_n = host_chip_select_n | (host_read_strobe_n & host_write_strobe_n);

	AST_NMI_VECTOR: assert property (nmi_take |-> nmi_vector == NMI_VECTOR_ADDR)
		else $error("nmi vector not loaded on take");
	AST_NMI_CLEARS: assert property (nmi_take && !$past(host_nmi_set) |-> !nmi_pending)
		else $error("nmi request not cleared on take");
	AST_NMI_CONTEXT: assert property (nmi_take |-> nmi_save_context == !$past(irq_context_skip_bit))
		else $error("context save flag wrong on take");
	AST_HALT_CAUSE: assert property ($rose(halt_acknowledge_bit) |->
		$past(halt_request_bit) && ($past(core_instr_boundary) || nmi_take))
		else $error("halt taken off an instruction boundary");
	AST_HALT_RELEASE: assert property (halt_acknowledge_bit && !halt_request_bit |=> !halt_acknowledge_bit)
		else $error("halt acknowledge not cleared on release");
	AST_HALT_STOPS_CORE: assert property (core_halted == halt_acknowledge_bit)
		else $error("core stop differs from acknowledge");
	AST_FLUSH_FOLLOWS: assert property (icache_flush == $past(cache_flush_bit))
		else $error("cache flush does not follow its bit");
	AST_READY_DROPS: assert property (host_strobe_n [*6] |-> !host_ready_out)
		else $error("ready stands without a request");
	AST_REG_CAPTURE: assert property (reg_wr_valid |-> (reg_wr_addr & IO_MASK) == IO_BASE
		&& reg_wr_data == $past(local_addr_data_bus, 3))
		else $error("register write not taken from the local bus");

	COV_NMI: cover property (nmi_take);
	COV_HALT: cover property ($rose(halt_acknowledge_bit));
	COV_REG: cover property (reg_wr_valid);
endmodule

bind host_port_ctrl host_port_props i_props (.*);

`default_nettype wire

// File: verif/mem_partner.sv
`timescale 1ns/100ps
`default_nettype none

// Local memory: one cycle in flight, a machine state plus extra_wait quarters long.
module mem_partner
	import host_port_pkg::*;
(
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic mem_req_valid,
	output logic mem_req_ready,
	output logic mem_cycle_done,
	input wire logic [3:0] extra_wait
);
	logic [4:0] left;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			left <= 5'h00;
			mem_cycle_done <= 1'b0;
		end else begin
			mem_cycle_done <= (left == 5'h01);
			if (mem_req_valid && mem_req_ready)
				left <= 5'h04 + {1'b0, extra_wait};
			else if (left != 5'h00)
				left <= left - 5'h01;
		end
	end

	// Refusing during the done pulse keeps one pulse per accepted cycle.
	assign mem_req_ready = (left == 5'h00) && !mem_cycle_done;
endmodule

`default_nettype wire

// File: verif/tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module tb_top
	import host_port_pkg::*;
;
	int err_total = 0;
	int num_checks = 0;
	int i;
	logic ref_clk, arst_n, host_chip_select_n, host_read_strobe_n, host_write_strobe_n;
	logic auto_increment_enable, prefetch_on_write_select, mem_req_ready, mem_cycle_done;
	logic halt_request_bit, host_nmi_set, irq_context_skip_bit, cache_flush_bit;
	logic core_instr_boundary, core_interruptible_point, host_ready_out, transceiver_dir_strobe;
	logic transceiver_output_enable_n, mem_req_valid, reg_wr_valid, halt_acknowledge_bit;
	logic core_halted, nmi_pending, nmi_take, nmi_save_context, icache_flush;
	logic [3:0] extra_wait;
	logic [BS_W-1:0] host_byte_selects;
	logic [ADDR_W-1:0] host_addr, reg_wr_addr, nmi_vector;
	logic [DATA_W-1:0] local_addr_data_bus, reg_wr_data;
	mem_req_t mem_req;
	mem_req_t seen[$];

	host_port_ctrl i_dut (.*);
	mem_partner i_mem (.*);

	always #50 ref_clk = ~ref_clk;

	always @(posedge ref_clk)
		if (mem_req_valid && mem_req_ready)
			seen.push_back(mem_req);

	task automatic wrap_up();
		if (err_total == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input string name, input logic [33:0] exp, input logic [33:0] got);
		num_checks++;
		if (got !== exp) begin
			$display("Error %s expected %h seen %h", name, exp, got);
			err_total++;
		end
	endtask

	task automatic lapse(input string name);
		$display("Error %s expected event seen timeout", name);
		err_total++;
		wrap_up();
	endtask

	task automatic chk_req(input int k, input logic [ADDR_W-1:0] a, input logic w, input logic p);
		chk("mem_req", {a, w, p}, seen[k]);
	endtask

	task automatic hreq(input logic wr, input logic cs_last);
		@(posedge ref_clk);
		if (wr)
			host_write_strobe_n <= 1'b0;
		else
			host_read_strobe_n <= 1'b0;
		if (cs_last) begin
			@(posedge ref_clk);
			host_chip_select_n <= 1'b0;
		end
		for (i = 0; i < 300 && host_ready_out !== 1'b1; i++)
			@(negedge ref_clk);
		if (i == 300)
			lapse("host_ready_out");
	endtask

	task automatic hrel(input logic cs_too);
		@(posedge ref_clk);
		host_read_strobe_n <= 1'b1;
		host_write_strobe_n <= 1'b1;
		if (cs_too)
			host_chip_select_n <= 1'b1;
		for (i = 0; i < 50 && host_ready_out !== 1'b0; i++)
			@(negedge ref_clk);
		if (i == 50)
			lapse("ready release");
	endtask

	task automatic wait_seen(input int n);
		for (i = 0; i < 300 && seen.size() < n; i++)
			@(negedge ref_clk);
		if (i == 300)
			lapse("memory request");
	endtask

	task automatic t_read_plain();
		seen.delete();
		@(posedge ref_clk);
		auto_increment_enable <= 1'b0;
		host_addr <= 32'h00001000;
		hreq(1'b0, 1'b1);
		chk("read count", 34'h1, 34'(seen.size()));
		chk_req(0, 32'h00001000, 1'b0, 1'b0);
		chk("dir strobe", 34'h1, 34'(transceiver_dir_strobe));
		hrel(1'b1);
	endtask

	task automatic t_read_prefetch();
		seen.delete();
		@(posedge ref_clk);
		auto_increment_enable <= 1'b1;
		prefetch_on_write_select <= 1'b0;
		host_addr <= 32'h00002000;
		host_byte_selects <= BS_ALL;
		@(posedge ref_clk);
		host_chip_select_n <= 1'b0;
		repeat (6) @(posedge ref_clk);
		host_addr <= 32'h0000f000;
		hreq(1'b0, 1'b0);
		chk_req(0, 32'h00002000, 1'b0, 1'b0);
		hrel(1'b0);
		wait_seen(2);
		chk("dir strobe busy", 34'h0, 34'(transceiver_dir_strobe));
		chk_req(1, 32'h00002004, 1'b0, 1'b1);
		@(posedge ref_clk);
		host_byte_selects <= BS_LOW_HALF;
		hreq(1'b0, 1'b0);
		hrel(1'b0);
		@(posedge ref_clk);
		host_byte_selects <= BS_HIGH_HALF;
		hreq(1'b0, 1'b0);
		hrel(1'b0);
		repeat (20) @(negedge ref_clk);
		chk("fetch count", 34'h3, 34'(seen.size()));
		chk_req(2, 32'h00002008, 1'b0, 1'b1);
		@(posedge ref_clk);
		host_chip_select_n <= 1'b1;
		host_byte_selects <= BS_ALL;
	endtask

	task automatic t_write_pair();
		seen.delete();
		@(posedge ref_clk);
		extra_wait <= 4'h8;
		prefetch_on_write_select <= 1'b0;
		host_addr <= 32'h00003000;
		local_addr_data_bus <= 32'h11223344;
		@(posedge ref_clk);
		host_chip_select_n <= 1'b0;
		hreq(1'b1, 1'b0);
		chk("early write", 34'h0, 34'(seen.size()));
		hrel(1'b0);
		hreq(1'b1, 1'b0);
		chk_req(0, 32'h00003000, 1'b1, 1'b0);
		hrel(1'b0);
		wait_seen(2);
		chk_req(1, 32'h00003004, 1'b1, 1'b0);
		@(posedge ref_clk);
		host_chip_select_n <= 1'b1;
	endtask

	task automatic t_write_prefetch();
		seen.delete();
		@(posedge ref_clk);
		prefetch_on_write_select <= 1'b1;
		host_addr <= 32'h00004000;
		@(posedge ref_clk);
		host_chip_select_n <= 1'b0;
		hreq(1'b1, 1'b0);
		hrel(1'b0);
		hreq(1'b0, 1'b0);
		chk("write then prefetch", 34'h2, 34'(seen.size()));
		chk_req(0, 32'h00004000, 1'b1, 1'b0);
		chk_req(1, 32'h00004004, 1'b0, 1'b1);
		hrel(1'b1);
		@(posedge ref_clk);
		extra_wait <= 4'h0;
	endtask

	task automatic t_reg_write();
		seen.delete();
		@(posedge ref_clk);
		auto_increment_enable <= 1'b0;
		host_addr <= IO_BASE + 32'h00000010;
		local_addr_data_bus <= 32'h5a5ac3c3;
		hreq(1'b1, 1'b1);
		hrel(1'b1);
		for (i = 0; i < 60 && transceiver_output_enable_n !== 1'b0; i++)
			@(negedge ref_clk);
		chk("oe during reg write", 34'h0, 34'(transceiver_output_enable_n));
		for (i = 0; i < 60 && reg_wr_valid !== 1'b1; i++)
			@(negedge ref_clk);
		if (i == 60)
			lapse("reg_wr_valid");
		chk("reg addr", 34'(IO_BASE + 32'h00000010), 34'(reg_wr_addr));
		chk("reg data", 34'h05a5ac3c3, 34'(reg_wr_data));
		repeat (20) @(negedge ref_clk);
		chk("reg mem count", 34'h0, 34'(seen.size()));
	endtask

	task automatic t_halt();
		@(posedge ref_clk);
		halt_request_bit <= 1'b1;
		repeat (20) @(negedge ref_clk);
		chk("ack mid instruction", 34'h0, 34'(halt_acknowledge_bit));
		@(posedge ref_clk);
		core_instr_boundary <= 1'b1;
		@(posedge ref_clk);
		core_instr_boundary <= 1'b0;
		for (i = 0; i < 20 && halt_acknowledge_bit !== 1'b1; i++)
			@(negedge ref_clk);
		if (i == 20)
			lapse("halt_acknowledge_bit");
		chk("core halted", 34'h1, 34'(core_halted));
		@(posedge ref_clk);
		halt_request_bit <= 1'b0;
		repeat (3) @(negedge ref_clk);
		chk("ack release", 34'h0, 34'(halt_acknowledge_bit));
	endtask

	task automatic t_nmi(input logic skip);
		@(posedge ref_clk);
		halt_request_bit <= 1'b1;
		cache_flush_bit <= 1'b1;
		irq_context_skip_bit <= skip;
		host_nmi_set <= 1'b1;
		@(posedge ref_clk);
		host_nmi_set <= 1'b0;
		core_interruptible_point <= 1'b1;
		for (i = 0; i < 20 && nmi_take !== 1'b1; i++)
			@(negedge ref_clk);
		if (i == 20)
			lapse("nmi_take");
		chk("vector", 34'(NMI_VECTOR_ADDR), 34'(nmi_vector));
		chk("save context", 34'(!skip), 34'(nmi_save_context));
		chk("nmi pending", 34'h0, 34'(nmi_pending));
		chk("cache flush", 34'h1, 34'(icache_flush));
		@(negedge ref_clk);
		chk("halt after nmi", 34'h1, 34'(halt_acknowledge_bit));
		@(posedge ref_clk);
		core_interruptible_point <= 1'b0;
		halt_request_bit <= 1'b0;
		cache_flush_bit <= 1'b0;
		repeat (3) @(negedge ref_clk);
		chk("resume", 34'h0, 34'(halt_acknowledge_bit));
	endtask

	initial begin
		ref_clk = 1'b0;
		arst_n = 1'b0;
		{host_chip_select_n, host_read_strobe_n, host_write_strobe_n} = 3'h7;
		{auto_increment_enable, prefetch_on_write_select, halt_request_bit} = 3'h0;
		{host_nmi_set, irq_context_skip_bit, cache_flush_bit} = 3'h0;
		{core_instr_boundary, core_interruptible_point} = 2'h0;
		host_byte_selects = BS_ALL;
		host_addr = ADDR_RESET;
		local_addr_data_bus = DATA_RESET;
		extra_wait = 4'h0;
		repeat (6) @(posedge ref_clk);
		arst_n <= 1'b1;
		repeat (4) @(posedge ref_clk);
		t_read_plain();
		t_read_prefetch();
		t_write_pair();
		t_write_prefetch();
		t_reg_write();
		t_halt();
		t_nmi(1'b0);
		t_nmi(1'b1);
		wrap_up();
	end
endmodule

`default_nettype wire
